/* chdp_pkg.sv */
package chdp_pkg;

  // bus widths and lane positions
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned LO_LANE  = 0;
  localparam int unsigned HI_LANE  = 1;

  // register index of the sector data port in the command block
  localparam logic [ADDR_W-1:0] DATA_REG_ADDR = 3'h0;

  // reset values of registered pin drives, and the zero byte for unused lanes
  localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO   = 8'h00;
  localparam logic [1:0]        LANES_OFF_N = 2'h3;

  // card personality chosen by the controller
  typedef enum logic [1:0] {
    memory_card_mode,
    io_card_mode,
    disk_interface_mode
  } chdp_mode_e;

  // multiword dma handshake states
  typedef enum logic [1:0] {
    dma_idle,
    dma_req,
    dma_act
  } chdp_dma_e;

  // every host pin that enters the block (all asynchronous)
  typedef struct packed {
    logic              iord_n;   // i/o read strobe
    logic              iowr_n;   // i/o write strobe
    logic              oe_n;     // memory read strobe
    logic              we_n;     // memory write strobe
    logic              dmack_n;  // dma acknowledge
    logic [1:0]        sel_n;    // [0] ce1/cs0, [1] ce2/cs1
    logic [ADDR_W-1:0] addr;     // low address lines
    logic [DATA_W-1:0] data;     // data bus as seen at the pins
  } chdp_pins_s;

  localparam int unsigned PINS_W = $bits(chdp_pins_s);

  // which byte lanes a cycle uses
  typedef struct packed {
    logic lo_en;  // d[7:0] carries a byte
    logic hi_en;  // d[15:8] carries a byte
    logic swap;   // odd byte rides on d[7:0]
  } chdp_lane_s;

  // one finished host access, handed to the controller
  typedef struct packed {
    logic              wr;     // 1 write into card, 0 read by host
    logic              dma;    // part of a dma burst
    logic              alt;    // cs1 range in disk interface mode
    logic              even;   // even byte involved
    logic              odd;    // odd byte involved
    logic [ADDR_W-1:0] addr;   // register index
  } chdp_acc_s;

endpackage : chdp_pkg

/* chdp_host_port.sv */
`timescale 1ns/1ps
// Overview of operation
// - d00 is lsb of even byte, d08 lsb of odd byte, except a ce1-only odd byte in card modes, which rides on d[7:0].
// - disk interface mode command block accesses, except the data port, are bytes on d[7:0].
// - disk interface mode sector data moves as 16-bit words on d[15:0].
// - io card mode: input acknowledge only when selected and answering a claimed read.
// - memory card mode keeps input acknowledge inactive.
// - disk interface mode raises dma request when data is ready to move.
// - dma direction follows strobe: read strobe to host, write strobe into card.
// - dma request held until acknowledge, then dropped; raised again if more remains.
// - dma request pin undriven whenever this card is not selected.
// - read strobe gates data out; write data latched on strobe trailing edge.
module chdp_host_port (
  input  wire logic                        core_clk_in,     // 10 MHz core clock
  input  wire logic                        sys_rst_in,      // sync reset, active high
  input  wire chdp_pkg::chdp_mode_e        mode_in,         // card personality
  input  wire logic                        dev_selected_in, // this unit addressed (disk mode)
  input  wire chdp_pkg::chdp_pins_s        pins_in,         // raw host pins
  output logic [chdp_pkg::DATA_W-1:0]      data_out,        // data bus drive value
  output logic [1:0]                       data_oe_n_out,   // lane enables, low drives
  output logic                             inpack_n_out,    // input acknowledge, low active
  output logic                             dmarq_out,       // dma request level
  output logic                             dmarq_oe_n_out,  // dma request enable, low drives
  output logic [chdp_pkg::ADDR_W-1:0]      addr_out,        // filtered address for decode
  input  wire logic                        addr_claim_in,   // controller owns addr_out
  input  wire logic [chdp_pkg::DATA_W-1:0] rd_data_in,      // word for current read
  input  wire logic                        dma_want_in,     // more dma data pending
  output logic                             acc_valid_out,   // one-cycle access event
  output chdp_pkg::chdp_acc_s              acc_out,         // access description
  output logic [chdp_pkg::DATA_W-1:0]      wdata_out,       // write data, even byte low
  output logic                             dma_active_out   // dma burst acknowledged
);

  localparam int unsigned PW = chdp_pkg::PINS_W;
  localparam int unsigned BW = chdp_pkg::BYTE_W;

  // pin synchronisers: three stages, then a filter that moves only when 2 and 3 agree
  logic [PW-1:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;
  logic [PW-1:0] nxt_filt;
  chdp_pkg::chdp_pins_s pin;

  always_comb begin
    nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));
    pin      = chdp_pkg::chdp_pins_s'(filt_ff);
  end

  // idle strobes are high, so the chain resets to all ones
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync1_ff <= {PW{1'b1}};
      sync2_ff <= {PW{1'b1}};
      sync3_ff <= {PW{1'b1}};
      filt_ff  <= {PW{1'b1}};
    end else begin
      sync1_ff <= pins_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= nxt_filt;
    end
  end

  // lane use per mode; ce decode in card modes, word or byte by target in disk mode
  function automatic chdp_pkg::chdp_lane_s lane_map(
    input chdp_pkg::chdp_mode_e        mode,
    input logic [1:0]                  sel_n,
    input logic [chdp_pkg::ADDR_W-1:0] addr,
    input logic                        dma
  );
    chdp_pkg::chdp_lane_s l;
    l = '0;
    if (mode == chdp_pkg::disk_interface_mode) begin
      if (dma || (!sel_n[0] && addr == chdp_pkg::DATA_REG_ADDR)) begin
        l.lo_en = 1'b1;
        l.hi_en = 1'b1;
      end else begin
        l.lo_en = 1'b1;
      end
    end else begin
      case (sel_n)
        2'b00: begin
          l.lo_en = 1'b1;
          l.hi_en = 1'b1;
        end
        2'b10: begin
          l.lo_en = 1'b1;
          l.swap  = addr[0];
        end
        2'b01: begin
          l.hi_en = 1'b1;
        end
        default: begin
          l = '0;
        end
      endcase
    end
    return l;
  endfunction : lane_map

  // dma handshake state
  chdp_pkg::chdp_dma_e dma_st_ff, nxt_dma_st;
  logic                dmarq_ff, nxt_dmarq;
  logic                dmarq_oe_n_ff, nxt_dmarq_oe_n;
  logic                disk_mode;

  // acknowledge is looked at only once a request is out, so a floating pin is harmless
  always_comb begin
    disk_mode  = (mode_in == chdp_pkg::disk_interface_mode);
    nxt_dma_st = dma_st_ff;
    case (dma_st_ff)
      chdp_pkg::dma_idle: begin
        if (disk_mode && dma_want_in) begin
          nxt_dma_st = chdp_pkg::dma_req;
        end
      end
      chdp_pkg::dma_req: begin
        if (!pin.dmack_n) begin
          nxt_dma_st = chdp_pkg::dma_act;
        end
      end
      chdp_pkg::dma_act: begin
        if (pin.dmack_n) begin
          nxt_dma_st = dma_want_in ? chdp_pkg::dma_req : chdp_pkg::dma_idle;
        end
      end
      default: begin
        nxt_dma_st = chdp_pkg::dma_idle;
      end
    endcase
    if (!disk_mode) begin
      nxt_dma_st = chdp_pkg::dma_idle;
    end
    nxt_dmarq      = (nxt_dma_st == chdp_pkg::dma_req);
    nxt_dmarq_oe_n = !(disk_mode && dev_selected_in);
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      dma_st_ff     <= chdp_pkg::dma_idle;
      dmarq_ff      <= 1'b0;
      dmarq_oe_n_ff <= 1'b1;
    end else begin
      dma_st_ff     <= nxt_dma_st;
      dmarq_ff      <= nxt_dmarq;
      dmarq_oe_n_ff <= nxt_dmarq_oe_n;
    end
  end

  // strobe decode, selection and read drive
  logic                          rd_strb, wr_strb, ce_any, dma_xfer, selected, rd_on;
  chdp_pkg::chdp_lane_s          lane;
  chdp_pkg::chdp_acc_s           cur_acc;
  logic [chdp_pkg::DATA_W-1:0]   dout_ff, nxt_dout;
  logic [1:0]                    oe_n_ff, nxt_oe_n;
  logic                          inpack_n_ff, nxt_inpack_n;

  always_comb begin
    rd_strb  = (mode_in == chdp_pkg::memory_card_mode) ? !pin.oe_n : !pin.iord_n;
    wr_strb  = (mode_in == chdp_pkg::memory_card_mode) ? !pin.we_n : !pin.iowr_n;
    ce_any   = (pin.sel_n != 2'b11);
    dma_xfer = disk_mode && (dma_st_ff == chdp_pkg::dma_act) && !pin.dmack_n;
    case (mode_in)
      chdp_pkg::memory_card_mode:    selected = ce_any;
      chdp_pkg::io_card_mode:        selected = ce_any && addr_claim_in;
      chdp_pkg::disk_interface_mode: selected = dma_xfer || (ce_any && dev_selected_in);
      default:                       selected = 1'b0;
    endcase
    lane          = lane_map(mode_in, pin.sel_n, pin.addr, dma_xfer);
    rd_on         = rd_strb && selected;
    cur_acc.wr    = 1'b0;
    cur_acc.dma   = dma_xfer;
    cur_acc.alt   = disk_mode && !dma_xfer && !pin.sel_n[1];
    cur_acc.even  = lane.lo_en && !lane.swap;
    cur_acc.odd   = lane.hi_en || lane.swap;
    cur_acc.addr  = pin.addr;
    // lanes float outside a read aimed at us; lane enables follow the byte decode
    nxt_oe_n = rd_on ? ~{lane.hi_en, lane.lo_en} : chdp_pkg::LANES_OFF_N;
    nxt_dout = {lane.hi_en ? rd_data_in[2*BW-1:BW] : chdp_pkg::BYTE_ZERO,
                lane.swap  ? rd_data_in[2*BW-1:BW] : rd_data_in[BW-1:0]};
    // memory mode and disk mode never assert input acknowledge
    nxt_inpack_n = !((mode_in == chdp_pkg::io_card_mode) && rd_on);
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      dout_ff     <= chdp_pkg::DATA_RST;
      oe_n_ff     <= chdp_pkg::LANES_OFF_N;
      inpack_n_ff <= 1'b1;
    end else begin
      dout_ff     <= nxt_dout;
      oe_n_ff     <= nxt_oe_n;
      inpack_n_ff <= nxt_inpack_n;
    end
  end

  // access events: read on strobe start, write on trailing edge with the last held data
  logic                        rd_prev_ff, nxt_rd_prev;
  logic                        wr_prev_ff, nxt_wr_prev;
  logic                        wr_sel_ff, nxt_wr_sel;
  chdp_pkg::chdp_acc_s         hold_acc_ff, nxt_hold_acc;
  logic [chdp_pkg::DATA_W-1:0] hold_data_ff, nxt_hold_data;
  logic                        acc_valid_ff, nxt_acc_valid;
  chdp_pkg::chdp_acc_s         acc_ff, nxt_acc;
  logic [chdp_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;

  // holding while the strobe is low means a late select drop cannot lose the write
  always_comb begin
    nxt_rd_prev   = rd_strb;
    nxt_wr_prev   = wr_strb;
    nxt_wr_sel    = wr_strb ? selected : 1'b0;
    nxt_hold_acc  = hold_acc_ff;
    nxt_hold_data = hold_data_ff;
    if (wr_strb) begin
      nxt_hold_acc    = cur_acc;
      nxt_hold_acc.wr = 1'b1;
      nxt_hold_data   = {lane.hi_en ? pin.data[2*BW-1:BW] :
                         (lane.swap ? pin.data[BW-1:0] : chdp_pkg::BYTE_ZERO),
                         (lane.lo_en && !lane.swap) ? pin.data[BW-1:0] : chdp_pkg::BYTE_ZERO};
    end
    nxt_acc_valid = 1'b0;
    nxt_acc       = acc_ff;
    nxt_wdata     = wdata_ff;
    if (rd_strb && !rd_prev_ff && selected) begin
      nxt_acc_valid = 1'b1;
      nxt_acc       = cur_acc;
    end else if (!wr_strb && wr_prev_ff && wr_sel_ff) begin
      nxt_acc_valid = 1'b1;
      nxt_acc       = hold_acc_ff;
      nxt_wdata     = hold_data_ff;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rd_prev_ff   <= 1'b0;
      wr_prev_ff   <= 1'b0;
      wr_sel_ff    <= 1'b0;
      hold_acc_ff  <= '0;
      hold_data_ff <= chdp_pkg::DATA_RST;
      acc_valid_ff <= 1'b0;
      acc_ff       <= '0;
      wdata_ff     <= chdp_pkg::DATA_RST;
    end else begin
      rd_prev_ff   <= nxt_rd_prev;
      wr_prev_ff   <= nxt_wr_prev;
      wr_sel_ff    <= nxt_wr_sel;
      hold_acc_ff  <= nxt_hold_acc;
      hold_data_ff <= nxt_hold_data;
      acc_valid_ff <= nxt_acc_valid;
      acc_ff       <= nxt_acc;
      wdata_ff     <= nxt_wdata;
    end
  end

  // outputs straight from flops, except dma_active_out, decoded from the dma state flops
  assign data_out       = dout_ff;
  assign data_oe_n_out  = oe_n_ff;
  assign inpack_n_out   = inpack_n_ff;
  assign dmarq_out      = dmarq_ff;
  assign dmarq_oe_n_out = dmarq_oe_n_ff;
  assign addr_out       = pin.addr;
  assign acc_valid_out  = acc_valid_ff;
  assign acc_out        = acc_ff;
  assign wdata_out      = wdata_ff;
  assign dma_active_out = (dma_st_ff == chdp_pkg::dma_act);

endmodule : chdp_host_port

/* chdp_host_port_monitor.sv */
`timescale 1ns/1ps
module chdp_host_port_monitor (
  input wire logic                 core_clk_in,     // clock
  input wire logic                 sys_rst_in,      // reset
  input wire chdp_pkg::chdp_mode_e mode_in,         // mode
  input wire logic                 dev_selected_in, // unit select
  input wire chdp_pkg::chdp_pins_s pins_in,         // host pins
  input wire logic [1:0]           data_oe_n_out,   // lanes
  input wire logic                 inpack_n_out,    // input ack
  input wire logic                 dmarq_out,       // request
  input wire logic                 dmarq_oe_n_out,  // request enable
  input wire logic                 dma_want_in,     // data pending
  input wire logic                 dma_active_out   // burst on
);
  logic mem;
  logic rstb;
  // read strobe of the active mode, so one check covers all three modes
  assign mem  = mode_in == chdp_pkg::memory_card_mode;
  assign rstb = mem ? pins_in.oe_n : pins_in.iord_n;
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_mem_ack; mem |-> inpack_n_out; endproperty
  a_mem_ack: assert property (p_mem_ack) else $error("ack in memory mode");
  property p_io_ack;
    $fell(inpack_n_out) |-> !$past(pins_in.iord_n, 2) && mode_in == chdp_pkg::io_card_mode;
  endproperty
  a_io_ack: assert property (p_io_ack) else $error("ack without io read");
  property p_drive; $changed(data_oe_n_out) && data_oe_n_out != 2'h3 |-> !$past(rstb, 2); endproperty
  a_drive: assert property (p_drive) else $error("lanes without read");
  property p_rq_oe;
    !dmarq_oe_n_out |-> $past(dev_selected_in) && $past(mode_in) == chdp_pkg::disk_interface_mode;
  endproperty
  a_rq_oe: assert property (p_rq_oe) else $error("request driven unselected");
  property p_rq_up;
    $rose(dma_want_in) && mode_in == chdp_pkg::disk_interface_mode && !dma_active_out
      |-> ##[1:3] dmarq_out;
  endproperty
  a_rq_up: assert property (p_rq_up) else $error("request late");
  property p_rq_hold; dmarq_out && pins_in.dmack_n && $past(pins_in.dmack_n, 2) |=> dmarq_out;
  endproperty
  a_rq_hold: assert property (p_rq_hold) else $error("request dropped early");
  property p_rq_drop; $fell(pins_in.dmack_n) && dmarq_out |-> ##[2:7] !dmarq_out; endproperty
  a_rq_drop: assert property (p_rq_drop) else $error("request kept");
  property p_ack_rq; $rose(dma_active_out) |-> $past(dmarq_out); endproperty
  a_ack_rq: assert property (p_ack_rq) else $error("burst without request");
  c_ack: cover property ($fell(inpack_n_out));
  c_burst: cover property ($rose(dma_active_out));
  c_rearm: cover property ($fell(dma_active_out) ##[1:8] dmarq_out);
endmodule : chdp_host_port_monitor
bind chdp_host_port chdp_host_port_monitor mon (.core_clk_in, .sys_rst_in, .mode_in,
  .dev_selected_in, .pins_in, .data_oe_n_out, .inpack_n_out, .dmarq_out, .dmarq_oe_n_out,
  .dma_want_in, .dma_active_out);

/* chdp_host_model.sv */
`timescale 1ns/1ps
module chdp_host_model (
  input  wire logic                 clk_in,       // core clock
  input  wire chdp_pkg::chdp_mode_e mode_in,      // card mode
  input  wire logic [15:0]          card_d_in,    // card data
  input  wire logic [1:0]           card_oe_n_in, // card lanes
  input  wire logic                 inpack_n_in,  // input ack
  output chdp_pkg::chdp_pins_s      pins_out      // host pins
);
  // one pin set serves every mode; no request input, so dma runs only when the bench asks
  chdp_pkg::chdp_pins_s p_ff = '1;
  logic [15:0]          wd_ff = 16'h0000;
  logic [15:0]          bus_ff = 16'h0000;
  logic [15:0]          rcap_ff;
  logic [15:0]          bus;
  logic                 wr_ff = 1'b0;
  // a lane nobody drives flips every cycle, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!card_oe_n_in[i]) bus[i*8+:8] = card_d_in[i*8+:8];
      else if (wr_ff) bus[i*8+:8] = wd_ff[i*8+:8];
      else bus[i*8+:8] = ~bus_ff[i*8+:8];
    end
    pins_out      = p_ff;
    pins_out.data = bus;
  end
  // input buffer opens only on the acknowledge
  always_ff @(posedge clk_in) begin
    bus_ff <= bus;
    if (!inpack_n_in) rcap_ff <= bus;
  end
  // select one cycle ahead of the strobe; a burst keeps both selects off
  task automatic start(input logic wr, input logic [1:0] s, input logic [2:0] a,
                       input logic [15:0] d);
    logic [3:0] st;
    @(posedge clk_in);
    st = {!wr, wr, !wr, wr} & {2'h3 * (mode_in != chdp_pkg::memory_card_mode),
                               2'h3 * (mode_in == chdp_pkg::memory_card_mode)};
    p_ff.sel_n <= p_ff.dmack_n ? s : 2'h3;
    p_ff.addr  <= a;
    wd_ff      <= d;
    wr_ff      <= wr;
    @(posedge clk_in);
    {p_ff.iord_n, p_ff.iowr_n, p_ff.oe_n, p_ff.we_n} <= ~st;
  endtask : start
  // data and selects outlast the trailing edge
  task automatic stop;
    @(posedge clk_in);
    {p_ff.iord_n, p_ff.iowr_n, p_ff.oe_n, p_ff.we_n} <= 4'hf;
    repeat (5) @(posedge clk_in);
    p_ff.sel_n <= 2'h3;
    wr_ff      <= 1'b0;
  endtask : stop
  task automatic dmack(input logic v);
    @(posedge clk_in);
    p_ff.dmack_n <= !v;
  endtask : dmack
endmodule : chdp_host_model

/* card_host_data_dma_port_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module card_host_data_dma_port_bench;
  logic                 clk = 1'b0, rst, dsel, claim, want;
  chdp_pkg::chdp_mode_e mode;
  chdp_pkg::chdp_pins_s pins;
  chdp_pkg::chdp_acc_s  acc, ev;
  logic [15:0]          rd, lfsr = 16'h52e0, dout, wdat, evd, aout;
  logic [1:0]           oe_n;
  logic                 inp_n, rq, rq_oe_n, av, act, dma_on = 1'b0;
  int                   num_errors = 0, checked = 0, nev = 0;
  initial forever #50 clk = ~clk;
  chdp_host_port dut (.core_clk_in(clk), .sys_rst_in(rst), .mode_in(mode),
    .dev_selected_in(dsel), .pins_in(pins), .data_out(dout), .data_oe_n_out(oe_n),
    .inpack_n_out(inp_n), .dmarq_out(rq), .dmarq_oe_n_out(rq_oe_n), .addr_out(aout),
    .addr_claim_in(claim), .rd_data_in(rd), .dma_want_in(want), .acc_valid_out(av),
    .acc_out(acc), .wdata_out(wdat), .dma_active_out(act));
  chdp_host_model host (.clk_in(clk), .mode_in(mode), .card_d_in(dout),
    .card_oe_n_in(oe_n), .inpack_n_in(inp_n), .pins_out(pins));
  // last access event, kept until the cycle is judged
  always @(posedge clk) if (av) begin
    ev  <= acc;
    evd <= wdat;
    nev <= nev + 1;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // lanes a read should drive; c is the io claim, or the unit select in disk mode
  function automatic logic [1:0] exp_oe(input chdp_pkg::chdp_mode_e m, input logic [1:0] s,
                                        input logic [2:0] a, input logic c);
    if (m != chdp_pkg::disk_interface_mode)
      return (m == chdp_pkg::io_card_mode && !c) ? 2'h3 : s;
    if (dma_on || (c && !s[0] && a == 3'h0)) return 2'h0;
    return (s == 2'h3 || !c) ? 2'h3 : 2'h2;
  endfunction : exp_oe
  task automatic rd_case(input chdp_pkg::chdp_mode_e m, input logic [1:0] s,
                         input logic [2:0] a, input logic c);
    logic [1:0]  eo;
    logic [15:0] mk;
    logic [15:0] ed;
    eo = exp_oe(m, s, a, c);
    mk = {{8{!eo[1]}}, {8{!eo[0]}}};
    ed = (m != chdp_pkg::disk_interface_mode && s == 2'h2 && a[0]) ? {8'h00, lfsr[15:8]} : lfsr;
    @(posedge clk);
    mode  <= m;
    claim <= c;
    dsel  <= c;
    rd    <= lfsr;
    lfsr   = nxt(lfsr);
    host.start(1'h0, s, a, 16'h0000);
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK("lanes", eo, oe_n)
    `CHK("rdata", ed & mk, dout & mk)
    `CHK("inpack", !(m == chdp_pkg::io_card_mode && eo != 2'h3), inp_n)
    `CHK("addr", a, aout)
    if (m == chdp_pkg::io_card_mode && eo != 2'h3) `CHK("buffer", ed & mk, host.rcap_ff & mk)
    host.stop;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("released", 3'h7, {inp_n, oe_n})
  endtask : rd_case
  task automatic wr_case(input chdp_pkg::chdp_mode_e m, input logic [1:0] s,
                         input logic [2:0] a);
    logic [15:0]         d;
    int                  n0;
    logic                w;
    chdp_pkg::chdp_acc_s ek;
    d    = lfsr;
    lfsr = nxt(lfsr);
    n0   = nev;
    // word or byte by target; the calls here always use the even byte
    w    = dma_on || ((m == chdp_pkg::disk_interface_mode) ? (!s[0] && a == 3'h0) : (s == 2'h0));
    ek   = {1'h1, dma_on, m == chdp_pkg::disk_interface_mode && !dma_on && !s[1], 1'h1, w, a};
    @(posedge clk);
    mode  <= m;
    claim <= 1'h1;
    dsel  <= 1'h1;
    host.start(1'h1, s, a, d);
    repeat (5) @(posedge clk);
    host.stop;
    repeat (3) @(posedge clk);
    `CHK("events", n0 + 1, nev)
    `CHK("wdata", w ? d : {8'h00, d[7:0]}, evd)
    `CHK("kind", ek, ev)
  endtask : wr_case
  // bounded wait for the request level; running out ends the run
  task automatic wait_rq(input logic v);
    @(negedge clk);
    repeat (40) if (rq !== v) @(negedge clk);
    `CHK("dmarq", v, rq)
    if (rq !== v) end_sim;
  endtask : wait_rq
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    chdp_pkg::chdp_mode_e m;
    logic [1:0]           s;
    // idle levels before the first edge sees them
    rst   <= 1'h1;
    dsel  <= 1'h1;
    claim <= 1'h0;
    want  <= 1'h0;
    mode  <= chdp_pkg::memory_card_mode;
    rd    <= 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    // corners: odd byte on low lane, unclaimed io read, disk data port and byte register
    rd_case(chdp_pkg::io_card_mode, 2'h2, 3'h1, 1'h1);
    rd_case(chdp_pkg::io_card_mode, 2'h0, 3'h0, 1'h0);
    rd_case(chdp_pkg::memory_card_mode, 2'h1, 3'h0, 1'h1);
    rd_case(chdp_pkg::disk_interface_mode, 2'h2, 3'h0, 1'h1);
    rd_case(chdp_pkg::disk_interface_mode, 2'h1, 3'h0, 1'h1);
    repeat (12) begin
      m = chdp_pkg::chdp_mode_e'(lfsr[3:2] % 2'h3);
      s = (m == chdp_pkg::disk_interface_mode && lfsr[1:0] == 2'h0) ? 2'h2 : lfsr[1:0];
      rd_case(m, s, lfsr[6:4], lfsr[7]);
    end
    wr_case(chdp_pkg::io_card_mode, 2'h0, 3'h0);
    wr_case(chdp_pkg::disk_interface_mode, 2'h2, 3'h3);
    // burst: request held unanswered, one word each way, rearm, then finish
    @(posedge clk);
    want <= 1'h1;
    wait_rq(1'h1);
    repeat (8) @(negedge clk);
    `CHK("held", 2'h2, {rq, rq_oe_n})
    host.dmack(1'h1);
    dma_on = 1'h1;
    wait_rq(1'h0);
    rd_case(chdp_pkg::disk_interface_mode, 2'h3, 3'h0, 1'h1);
    wr_case(chdp_pkg::disk_interface_mode, 2'h3, 3'h0);
    host.dmack(1'h0);
    dma_on = 1'h0;
    wait_rq(1'h1);
    @(posedge clk);
    want <= 1'h0;
    host.dmack(1'h1);
    wait_rq(1'h0);
    host.dmack(1'h0);
    repeat (10) @(negedge clk);
    `CHK("idle", 2'h0, {rq, act})
    host.dmack(1'h1);
    repeat (10) @(negedge clk);
    `CHK("ignored", 2'h0, {rq, act})
    host.dmack(1'h0);
    dsel <= 1'h0;
    repeat (3) @(negedge clk);
    `CHK("rq_float", 1'h1, rq_oe_n)
    end_sim;
  end
endmodule : card_host_data_dma_port_bench
